// >>> verilog/tfw_pkg.sv
// Shared constants for the test/transfer/wait decode block.
// Assumes a byte-wide program memory with one-cycle read latency.
package tfw_pkg;
	// ============================================================
	// Opcodes
	localparam logic [7:0] OP_TEST_DIR  = 8'h3D;
	localparam logic [7:0] OP_TEST_ACC  = 8'h4D;
	localparam logic [7:0] OP_TEST_IDX  = 8'h5D;
	localparam logic [7:0] OP_TEST_IX1  = 8'h6D;
	localparam logic [7:0] OP_TEST_IX   = 8'h7D;
	localparam logic [7:0] OP_COPY_XA   = 8'h9F;
	localparam logic [7:0] OP_WAIT      = 8'h8F;
	// Extra forms for the effective-address modes
	localparam logic [7:0] OP_TEST_EXT  = 8'hCD;
	localparam logic [7:0] OP_TEST_IX2  = 8'hDD;
	// ============================================================
	// Cycle counts per instruction
	localparam logic [3:0] CYC_DIR  = 4'h4;
	localparam logic [3:0] CYC_INH1 = 4'h3;
	localparam logic [3:0] CYC_IX1  = 4'h5;
	localparam logic [3:0] CYC_IX   = 4'h4;
	localparam logic [3:0] CYC_IMPL = 4'h2;
	localparam logic [3:0] CYC_EXT  = 4'h5;
	localparam logic [3:0] CYC_IX2  = 4'h6;
	// ============================================================
	// Flag bit positions in condition_flags (H I N Z C)
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_I = 3;
	localparam int FLG_H = 4;
	// Reset values
	localparam logic [4:0] FLAGS_RST = 5'h08;
	localparam logic [15:0] PC_RST   = 16'h0000;
	// ============================================================
	// Addressing modes
	typedef enum logic [2:0] {
		TFW_IMPLIED_MODE,
		TFW_DIRECT_MODE,
		TFW_FULL_ADDRESS_MODE,
		TFW_PLAIN_INDEXED_MODE,
		TFW_BYTE_OFFSET_INDEXED_MODE,
		TFW_WORD_OFFSET_INDEXED_MODE
	} tfw_mode_t;
endpackage

// >>> verilog/tfw_ea.sv
// Effective-address former for the memory forms.
// Assumes operand bytes are already captured by the sequencer.
`timescale 1ns/1ns
module tfw_ea #(
	parameter int AW = 16
) (
	input  wire tfw_pkg::tfw_mode_t mode,
	input  wire logic [7:0]         index_reg,
	input  wire logic [7:0]         hi_byte,
	input  wire logic [7:0]         lo_byte,
	output logic [AW-1:0]           eff_addr
);
	// Two operand bytes make the widest address, so narrower buses cannot serve
	if (AW < 16) begin : g_aw_check
		$error("tfw_ea needs AW of at least 16");
	end

	// ============================================================
	// Address forms
	wire [AW-1:0] x_ext   = {{(AW-8){1'b0}}, index_reg};
	wire [AW-1:0] ofs8    = {{(AW-8){1'b0}}, lo_byte};
	wire [AW-1:0] ofs16   = {{(AW-16){1'b0}}, hi_byte, lo_byte};
	wire [AW-1:0] ea_dir  = ofs8;
	wire [AW-1:0] ea_ext  = ofs16;          // [RL6]
	wire [AW-1:0] ea_ix   = x_ext;          // [RL7]
	wire [AW-1:0] ea_ix1  = x_ext + ofs8;   // [RL4]
	wire [AW-1:0] ea_ix2  = x_ext + ofs16;  // [RL5]

	// Mode select
	always_comb begin
		case (mode)
			tfw_pkg::TFW_DIRECT_MODE:              eff_addr = ea_dir;
			tfw_pkg::TFW_FULL_ADDRESS_MODE:        eff_addr = ea_ext;
			tfw_pkg::TFW_PLAIN_INDEXED_MODE:       eff_addr = ea_ix;
			tfw_pkg::TFW_BYTE_OFFSET_INDEXED_MODE: eff_addr = ea_ix1;
			tfw_pkg::TFW_WORD_OFFSET_INDEXED_MODE: eff_addr = ea_ix2;
			default:                               eff_addr = '0;
		endcase
	end
endmodule

// >>> verilog/tfw_core.sv
// Decode/execute sequencer for test, copy-index and wait instructions.
// Assumes program/data memory returns rd_data one cycle after mem_addr.
//
// What this block does
// RL1 - Test compares its operand with zero, updates only N and Z, never writes the operand.
// RL2 - Opcode 9F copies index into accumulator in 2 cycles and leaves all flags alone.
// RL3 - Opcode 8F clears the interrupt mask and halts the clock in 2 cycles, other flags kept.
// RL4 - Byte-offset indexed mode fetches one offset byte and adds it unsigned to index.
// RL5 - Word-offset indexed mode fetches high then low offset byte and adds to index.
// RL6 - Full-address mode fetches high then low address bytes and uses them directly.
// RL7 - Plain indexed mode uses the zero-extended index as the address.
`timescale 1ns/1ns
module tfw_core #(
	parameter int AW = 16
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	input  wire logic [7:0]    rd_data,
	input  wire logic          wake,
	input  wire logic [7:0]    index_in,
	input  wire logic          index_load,
	output logic [AW-1:0]      mem_addr,
	output logic               clock_halted,
	output logic [4:0]         condition_flags,
	output logic [7:0]         acc,
	output logic [7:0]         index_reg,
	output logic               instr_done,
	output logic               bad_opcode
);
	// Two operand bytes make the widest address, so narrower buses cannot serve
	if (AW < 16) begin : g_aw_check
		$error("tfw_core needs AW of at least 16");
	end

	// ============================================================
	// State
	typedef enum logic [2:0] {
		TFW_FETCH, TFW_DECODE, TFW_OPND1, TFW_OPND2, TFW_READ, TFW_EXEC, TFW_HALT
	} tfw_state_t;

	tfw_state_t          st_q, st_d;
	tfw_pkg::tfw_mode_t  mode_q, mode_d;
	logic [AW-1:0]       pc_q;
	logic [7:0]          op_q, hi_q, lo_q;
	logic [3:0]          cyc_q;
	logic [3:0]          need_q;
	logic [AW-1:0]       ea;

	tfw_ea #(.AW(AW)) u_ea (
		.mode      (mode_q),
		.index_reg (index_reg),
		.hi_byte   (hi_q),
		.lo_byte   (lo_q),
		.eff_addr  (ea)
	);

	// ============================================================
	// Opcode decode
	wire dec_op = (st_q == TFW_DECODE);
	wire is_dir = rd_data == tfw_pkg::OP_TEST_DIR;
	wire is_acc = rd_data == tfw_pkg::OP_TEST_ACC;
	wire is_idx = rd_data == tfw_pkg::OP_TEST_IDX;
	wire is_ix1 = rd_data == tfw_pkg::OP_TEST_IX1;
	wire is_ix  = rd_data == tfw_pkg::OP_TEST_IX;
	wire is_ext = rd_data == tfw_pkg::OP_TEST_EXT;
	wire is_ix2 = rd_data == tfw_pkg::OP_TEST_IX2;
	wire is_cxa = rd_data == tfw_pkg::OP_COPY_XA;
	wire is_wt  = rd_data == tfw_pkg::OP_WAIT;
	wire known  = is_dir | is_acc | is_idx | is_ix1 | is_ix | is_ext | is_ix2 | is_cxa | is_wt;
	wire [3:0] need_dec = is_dir ? tfw_pkg::CYC_DIR  : is_ix1 ? tfw_pkg::CYC_IX1 :
	                      is_ix  ? tfw_pkg::CYC_IX   : is_ext ? tfw_pkg::CYC_EXT :
	                      is_ix2 ? tfw_pkg::CYC_IX2  : (is_acc | is_idx) ? tfw_pkg::CYC_INH1 :
	                      tfw_pkg::CYC_IMPL;
	// Operand for test: memory byte, accumulator or index
	wire [7:0] tst_val = (op_q == tfw_pkg::OP_TEST_ACC) ? acc :
	                     (op_q == tfw_pkg::OP_TEST_IDX) ? index_reg : rd_data;
	wire two_bytes = (mode_q == tfw_pkg::TFW_FULL_ADDRESS_MODE) |
	                 (mode_q == tfw_pkg::TFW_WORD_OFFSET_INDEXED_MODE);
	wire mem_form  = (mode_q != tfw_pkg::TFW_IMPLIED_MODE);
	// Exec fires once the documented cycle budget is spent
	wire at_end = (cyc_q + 4'h1 >= need_q);

	// Next state
	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		case (st_q)
			TFW_FETCH: st_d = TFW_DECODE;
			TFW_DECODE: begin
				mode_d = (is_dir) ? tfw_pkg::TFW_DIRECT_MODE :
				         (is_ext) ? tfw_pkg::TFW_FULL_ADDRESS_MODE :
				         (is_ix)  ? tfw_pkg::TFW_PLAIN_INDEXED_MODE :
				         (is_ix1) ? tfw_pkg::TFW_BYTE_OFFSET_INDEXED_MODE :
				         (is_ix2) ? tfw_pkg::TFW_WORD_OFFSET_INDEXED_MODE :
				         tfw_pkg::TFW_IMPLIED_MODE;
				if (!known)
					st_d = TFW_FETCH;
				else if (is_dir | is_ix1 | is_ext | is_ix2)
					st_d = TFW_OPND1;
				else if (is_ix)
					st_d = TFW_READ;
				else
					st_d = TFW_EXEC;
			end
			TFW_OPND1: st_d = two_bytes ? TFW_OPND2 : TFW_READ;
			TFW_OPND2: st_d = TFW_READ;
			TFW_READ:  st_d = TFW_EXEC;
			TFW_EXEC:  st_d = at_end ? ((op_q == tfw_pkg::OP_WAIT) ? TFW_HALT : TFW_FETCH)
			                         : TFW_EXEC;
			TFW_HALT:  st_d = wake ? TFW_FETCH : TFW_HALT;
			default:   st_d = TFW_FETCH;
		endcase
	end

	// ============================================================
	// Sequencer registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q   <= TFW_FETCH;
			mode_q <= tfw_pkg::TFW_IMPLIED_MODE;
			cyc_q  <= 4'h0;
			need_q <= 4'h0;
			op_q   <= 8'h00;
		end else begin
			st_q   <= st_d;
			mode_q <= mode_d;
			cyc_q  <= (st_q == TFW_FETCH) ? 4'h0 : cyc_q + 4'h1;
			if (dec_op) begin
				need_q <= need_dec;
				op_q   <= rd_data;
			end
		end
	end

	// Operand bytes: high first, then low; single byte lands in low
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
		end else if (dec_op) begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
		end else if (st_q == TFW_OPND1 && two_bytes) begin
			hi_q <= rd_data;  // [RL5] [RL6]
		end else if (st_q == TFW_OPND1 || st_q == TFW_OPND2) begin
			lo_q <= rd_data;  // [RL4] [RL5] [RL6]
		end
	end

	// Address for the next fetch/operand step and for the read step.
	// Memory answers a cycle late, so the byte after pc is put out one step ahead.
	wire [AW-1:0] pc_one    = {{(AW-1){1'b0}}, 1'b1};
	wire [AW-1:0] pc_d_addr = (st_d == TFW_DECODE || st_d == TFW_OPND1 ||
	                          st_d == TFW_OPND2) ? pc_q + pc_one : pc_q;
	wire [AW-1:0] index_ea_now = {{(AW-8){1'b0}}, index_reg};  // [RL7]
	wire [AW-1:0] lo_ext  = {{(AW-8){1'b0}}, rd_data};
	wire [AW-1:0] hilo    = {{(AW-16){1'b0}}, hi_q, rd_data};
	wire [AW-1:0] x_ext   = {{(AW-8){1'b0}}, index_reg};
	wire [AW-1:0] ea_ix1  = x_ext + lo_ext;
	wire [AW-1:0] ea_ix2  = x_ext + hilo;
	// Fold the arriving byte in, so the read is issued without a spare cycle
	wire [AW-1:0] ea_next = (mode_q == tfw_pkg::TFW_DIRECT_MODE) ? lo_ext :
	                        (mode_q == tfw_pkg::TFW_FULL_ADDRESS_MODE) ? hilo :          // [RL6]
	                        (mode_q == tfw_pkg::TFW_BYTE_OFFSET_INDEXED_MODE) ? ea_ix1 : // [RL4]
	                        (mode_q == tfw_pkg::TFW_WORD_OFFSET_INDEXED_MODE) ? ea_ix2 : // [RL5]
	                        ea;

	// Program counter and memory address
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pc_q     <= AW'(tfw_pkg::PC_RST);
			mem_addr <= AW'(tfw_pkg::PC_RST);
		end else begin
			if (st_d == TFW_DECODE || st_d == TFW_OPND1 || st_d == TFW_OPND2)
				pc_q <= pc_q + pc_one;
			// Data address only after the last operand byte lands
			mem_addr <= (st_d == TFW_READ) ? ((st_q == TFW_DECODE) ? index_ea_now : ea_next)
			                               : pc_d_addr;
		end
	end

	// ============================================================
	// Execute: flags, accumulator, index, halt
	wire exec_fire = (st_q == TFW_EXEC) && at_end;
	logic [7:0] rd_q;
	logic       rd_pend_q;
	// Data byte arrives the cycle after READ; held for the later exec steps
	wire [7:0] mem_val  = rd_pend_q ? rd_data : rd_q;
	wire [7:0] tst_live = mem_form ? mem_val : tst_val;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_q      <= 8'h00;
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= (st_q == TFW_READ);
			if (rd_pend_q)
				rd_q <= rd_data;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			condition_flags <= tfw_pkg::FLAGS_RST;
			acc             <= 8'h00;
			index_reg       <= 8'h00;
			clock_halted    <= 1'b0;
			instr_done      <= 1'b0;
			bad_opcode      <= 1'b0;
		end else begin
			instr_done <= exec_fire;
			bad_opcode <= dec_op && !known;
			if (index_load)
				index_reg <= index_in;
			if (exec_fire && op_q == tfw_pkg::OP_COPY_XA)
				acc <= index_reg;                                   // [RL2]
			if (exec_fire && op_q == tfw_pkg::OP_WAIT)
				condition_flags[tfw_pkg::FLG_I] <= 1'b0;            // [RL3]
			if (exec_fire && op_q != tfw_pkg::OP_COPY_XA && op_q != tfw_pkg::OP_WAIT) begin
				condition_flags[tfw_pkg::FLG_N] <= tst_live[7];     // [RL1]
				condition_flags[tfw_pkg::FLG_Z] <= (tst_live == 8'h00); // [RL1]
			end
			// Halted until wake; wake-up sequence lives elsewhere
			if (exec_fire && op_q == tfw_pkg::OP_WAIT)
				clock_halted <= 1'b1;                               // [RL3]
			else if (st_q == TFW_HALT && wake)
				clock_halted <= 1'b0;
		end
	end

	// ============================================================
	// Checks
	a_copy_no_flags: assert property (@(posedge clock) disable iff (!rstn)
		(exec_fire && op_q == tfw_pkg::OP_COPY_XA) |=> $stable(condition_flags)
			&& acc == $past(index_reg)) else $error("copy changed flags"); // [RL2]
	a_wait_halts: assert property (@(posedge clock) disable iff (!rstn)
		(exec_fire && op_q == tfw_pkg::OP_WAIT) |=> clock_halted
			&& !condition_flags[tfw_pkg::FLG_I]) else $error("wait did not halt"); // [RL3]
	a_wait_keeps: assert property (@(posedge clock) disable iff (!rstn)
		(exec_fire && op_q == tfw_pkg::OP_WAIT) |=>
			condition_flags[2:0] == $past(condition_flags[2:0])
			&& condition_flags[4] == $past(condition_flags[4])) else $error("wait hit flags"); // [RL3]
	a_test_keeps: assert property (@(posedge clock) disable iff (!rstn)
		(exec_fire && op_q[3:0] == 4'hD) |=> $stable(acc)
			&& condition_flags[tfw_pkg::FLG_C] == $past(condition_flags[tfw_pkg::FLG_C]))
		else $error("test changed state"); // [RL1]
	a_test_zero: assert property (@(posedge clock) disable iff (!rstn)
		(exec_fire && op_q[3:0] == 4'hD) |=>
			condition_flags[tfw_pkg::FLG_Z] == ($past(tst_live) == 8'h00)) else $error("bad Z"); // [RL1]
	a_copy_time: assert property (@(posedge clock) disable iff (!rstn)
		(dec_op && rd_data == tfw_pkg::OP_COPY_XA) |=> exec_fire) else $error("copy timing"); // [RL2]
	a_ix1_addr: assert property (@(posedge clock) disable iff (!rstn)
		(st_q == TFW_OPND1 && mode_q == tfw_pkg::TFW_BYTE_OFFSET_INDEXED_MODE)
			|=> mem_addr == $past(x_ext + lo_ext)) else $error("ix1 address"); // [RL4]
	a_ix2_addr: assert property (@(posedge clock) disable iff (!rstn)
		(st_q == TFW_OPND2 && mode_q == tfw_pkg::TFW_WORD_OFFSET_INDEXED_MODE)
			|=> mem_addr == $past(x_ext + hilo)) else $error("ix2 address"); // [RL5]
	a_ext_addr: assert property (@(posedge clock) disable iff (!rstn)
		(st_q == TFW_OPND2 && mode_q == tfw_pkg::TFW_FULL_ADDRESS_MODE)
			|=> mem_addr == $past(hilo)) else $error("ext address"); // [RL6]
	a_ix_addr: assert property (@(posedge clock) disable iff (!rstn)
		(dec_op && rd_data == tfw_pkg::OP_TEST_IX) |=> mem_addr == $past(x_ext))
		else $error("ix address"); // [RL7]
endmodule

// >>> tb/tfw_prog_mem.sv
// Program and data memory model facing the decode block.
// Assumes the bench preloads mem before it releases reset.
`timescale 1ns/1ns
module tfw_prog_mem (
	input  wire logic        clock,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       rd_data
);
	logic [7:0] mem [0:65535];

	// ============================================================
	// Registered read: the byte for last cycle's address
	always_ff @(posedge clock) begin
		rd_data <= mem[mem_addr];
	end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for tfw_core: preloads a program, checks each result.
// Assumes tfw_prog_mem answers one cycle after mem_addr.
`timescale 1ns/1ns
module testbench;
	typedef struct packed {logic [7:0] acc; logic [4:0] flg;} tfw_exp_t;
	logic        clock, rstn, wake, index_load, clock_halted, instr_done, bad_opcode;
	logic [7:0]  rd_data, index_in, acc, index_reg;
	logic [15:0] mem_addr;
	logic [4:0]  condition_flags, flg;
	int          n_mismatch, n_checks, n_done;
	tfw_exp_t    exp_q[$];
	tfw_exp_t    e;

	// ============================================================
	// Clock and instances
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	tfw_core u_dut (.clock(clock), .rstn(rstn), .rd_data(rd_data), .wake(wake),
		.index_in(index_in), .index_load(index_load), .mem_addr(mem_addr),
		.clock_halted(clock_halted), .condition_flags(condition_flags), .acc(acc),
		.index_reg(index_reg), .instr_done(instr_done), .bad_opcode(bad_opcode));
	tfw_prog_mem u_mem (.clock(clock), .mem_addr(mem_addr), .rd_data(rd_data));

	// ============================================================
	// Shared checking and closing tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Bounded wait: a lost completion must not hang the run
	task automatic wait_done(input int target);
		int k;
		k = 0;
		while (n_done < target && k < 60) begin
			@(negedge clock);
			k++;
		end
		if (n_done < target) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	// Flags after a test of value v; only N and Z move
	task automatic exp_nz(input logic [7:0] a, input logic [7:0] v);
		flg[tfw_pkg::FLG_N] = v[7];
		flg[tfw_pkg::FLG_Z] = (v == 8'h00);
		exp_q.push_back('{a, flg});
	endtask

	// ============================================================
	// Result watcher: oldest note against each completion
	always @(negedge clock) begin
		if (instr_done === 1'b1) begin
			n_done++;
			if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				chk(acc, e.acc);
				chk({3'h0, condition_flags}, {3'h0, e.flg});
			end
		end
	end

	// ============================================================
	// Main sequence: two rounds, the second reset lands mid-run
	initial begin
		logic [7:0] x, ofs, lo, d3;
		logic [7:0] prog [16];
		int k;
		rstn = 1'b0;
		wake = 1'b0;
		index_load = 1'b0;
		index_in = 8'h00;
		n_mismatch = 0;
		n_checks = 0;
		n_done = 0;
		void'($urandom(32'hB022D238));
		for (int r = 0; r < 2; r++) begin
			@(negedge clock);
			rstn = 1'b0;
			// Index high half and offset high bit force a carry past bit 7
			x = 8'h80 | 8'($urandom);
			ofs = 8'h80 | 8'($urandom);
			lo = 8'($urandom);
			d3 = 8'h80 | 8'($urandom);
			prog = '{8'h4D, 8'h9F, 8'h5D, 8'h3D, 8'h40, 8'h6D, ofs, 8'h7D,
				8'hCD, 8'h12, 8'h34, 8'hDD, 8'h03, lo, 8'h8F, 8'h9F};
			// Fill value is no opcode and tests as neither N nor Z
			for (int i = 0; i < 65536; i++) begin
				u_mem.mem[i] = 8'h01;
			end
			for (int i = 0; i < 16; i++) begin
				u_mem.mem[i] = prog[i];
			end
			u_mem.mem[16'h0040] = 8'h00;
			u_mem.mem[{8'h00, x} + {8'h00, ofs}] = 8'h80;
			u_mem.mem[{8'h00, x}] = 8'h00;
			u_mem.mem[16'h1234] = d3;
			u_mem.mem[{8'h00, x} + {8'h03, lo}] = 8'h00;
			exp_q.delete();
			flg = 5'h08;
			exp_nz(8'h00, 8'h00);
			exp_q.push_back('{x, flg});
			exp_nz(x, x);
			exp_nz(x, 8'h00);
			exp_nz(x, 8'h80);
			exp_nz(x, 8'h00);
			exp_nz(x, d3);
			exp_nz(x, 8'h00);
			flg[tfw_pkg::FLG_I] = 1'b0;
			exp_q.push_back('{x, flg});
			exp_q.push_back('{x, flg});
			repeat (8) @(negedge clock);
			n_done = 0;
			rstn = 1'b1;
			index_in = x;
			index_load = 1'b1;
			repeat (2) @(negedge clock);
			index_load = 1'b0;
			wait_done(9);
			// Halted: nothing completes until wake
			repeat (6) @(negedge clock);
			chk({7'h00, clock_halted}, 8'h01);
			chk(8'(n_done), 8'h09);
			wake = 1'b1;
			@(negedge clock);
			wake = 1'b0;
			wait_done(10);
			k = 0;
			while (bad_opcode !== 1'b1 && k < 20) begin
				@(negedge clock);
				k++;
			end
			chk({7'h00, bad_opcode}, 8'h01);
			chk(acc, x);
			chk(index_reg, x);
			chk(8'(exp_q.size()), 8'h00);
			$display("round %0d finished", r);
		end
		report_and_stop();
	end
endmodule
